// [design/gclk_gen_ctrl.sv]
// generic clock generators with their control registers on AHB-Lite
`timescale 1ns/1ns
`default_nettype none
module gclk_gen_ctrl
   import gclk_pkg::*;
#(
   parameter int NUM_GEN = NUM_GEN_DEF
)(
   input  wire logic               CLK_SYS,
   input  wire logic               RST,
   input  wire logic               HSEL,
   input  wire logic [31:0]        HADDR,
   input  wire logic [1:0]         HTRANS,
   input  wire logic               HWRITE,
   input  wire logic [2:0]         HSIZE,
   input  wire logic [31:0]        HWDATA,
   input  wire logic               HREADY,
   output var  logic [31:0]        HRDATA,
   output var  logic               HREADYOUT,
   output var  logic               HRESP,
   input  wire logic [NUM_SRC-1:0] SRC_CLK,
   input  wire logic [NUM_GEN-1:0] PERIPH_REQ,
   input  wire logic               STANDBY,
   output var  logic [NUM_GEN-1:0] GEN_CLK,
   output var  logic [NUM_GEN-1:0] GENERATOR_CLOCK_PIN_O,
   output var  logic [NUM_GEN-1:0] GENERATOR_CLOCK_PIN_OE
);

   localparam int NUM_SLOT = 2 ** IDX_W;

   gen_ctrl_type     ctrl_q [NUM_SLOT];
   dphase_type       dph_q;
   dphase_type       dph_d;
   logic [31:0]      rdata_q;
   logic [31:0]      rd_val;
   logic [31:0]      fwd_val;
   logic [IDX_W-1:0] a_idx;
   logic             a_valid;
   logic             a_hit;
   logic             wr_en;
   logic             fwd;
   logic [NUM_GEN-1:0] run;
   logic [NUM_GEN-1:0] div_clk;
   logic [NUM_GEN-1:0] pin_q;

   // ====================================================
   // address phase decode
   assign a_idx   = HADDR[IDX_LSB+IDX_W-1:IDX_LSB];
   assign a_valid = HSEL & HTRANS[1] & HREADY;
   assign a_hit   = a_valid
                    && (HADDR[ADDR_W-1:IDX_LSB+IDX_W] == '0)
                    && (HADDR[IDX_LSB-1:0] == '0)
                    && (HSIZE == SIZE_WORD)
                    && (int'(a_idx) < NUM_GEN);

   assign dph_d.wr  = a_hit & HWRITE;
   assign dph_d.rd  = a_hit & ~HWRITE;
   assign dph_d.idx = a_idx;

   // ====================================================
   // data phase and read path
   assign wr_en   = dph_q.wr;
   assign fwd     = wr_en && (dph_q.idx == a_idx);
   assign fwd_val = HWDATA & write_mask(int'(a_idx));
   assign rd_val  = !dph_d.rd ? RD_ZERO
                  : fwd ? fwd_val
                  : ctrl_q[a_idx];

   assign HRDATA    = rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         dph_q   <= '0;
         rdata_q <= RD_ZERO;
      end else if (HREADY) begin
         dph_q   <= dph_d;
         rdata_q <= rd_val;
      end
   end

   // ====================================================
   // per-generator registers, divider and pin
   for (genvar n = 0; n < NUM_SLOT; n++) begin : g_gen
      if (n < NUM_GEN) begin : g_real
         localparam logic [IDX_W-1:0] MY_IDX = IDX_W'(n);
         logic         sel_src;
         gen_ctrl_type c;

         assign c = ctrl_q[n];

         always_ff @(posedge CLK_SYS) begin
            if (RST) begin
               ctrl_q[n] <= CTRL_RST;
            end else if (wr_en && dph_q.idx == MY_IDX) begin
               ctrl_q[n] <= HWDATA & write_mask(n);
            end
         end

         assign sel_src = SRC_CLK[c.source_select];

         // with generator_enable set, peripheral request always counts; pin adds run
         // unless standby without keep-alive
         assign run[n] = c.generator_enable
                         & (PERIPH_REQ[n]
                            | (c.pin_drive_enable
                               & (~STANDBY | c.standby_keep_alive)));

         gen_divider u_div (
            .clk_sys  (CLK_SYS),
            .rst      (RST),
            .src_lvl  (sel_src),
            .run      (run[n]),
            .ratio    (ratio_of(c)),
            .duty_bal (c.duty_balance_enable),
            .clk_out  (div_clk[n])
         );

         always_ff @(posedge CLK_SYS) begin
            if (RST) begin
               pin_q[n] <= 1'b0;
            end else if (!c.pin_drive_enable) begin
               pin_q[n] <= 1'b0;
            end else if (STANDBY && !c.standby_keep_alive) begin
               pin_q[n] <= c.idle_pin_level;
            end else if (!run[n]) begin
               pin_q[n] <= c.idle_pin_level;
            end else begin
               pin_q[n] <= div_clk[n];
            end
         end

         assign GEN_CLK[n]                = div_clk[n];
         assign GENERATOR_CLOCK_PIN_O[n]  = pin_q[n];
         assign GENERATOR_CLOCK_PIN_OE[n] = c.pin_drive_enable;

         // ==============================================
         // per-generator checks
         sequence s_wr_to_me;
            a_hit && HWRITE && a_idx == MY_IDX ##1 1'b1;
         endsequence

         property p_write_masked;
            logic [31:0] w;
            (s_wr_to_me, w = HWDATA)
            |=> ctrl_q[n] == (w & write_mask(n));
         endproperty

         AST_WRITE_MASKED: assert property (
            @(posedge CLK_SYS) disable iff (RST) p_write_masked)
            else $error("control write not stored with its mask");

         if (n == 0) begin : g_g0
            AST_DIV_G0: assert property (
               @(posedge CLK_SYS) disable iff (RST)
               c.div[15:DIV_BITS_G0] == '0)
               else $error("generator 0 holds divide bits above 7");
         end else if (n == 1) begin : g_g1
            AST_DIV_G1: assert property (
               @(posedge CLK_SYS) disable iff (RST)
               s_wr_to_me |=> c.div == $past(HWDATA[31:DIV_LSB]))
               else $error("generator 1 lost divide bits");
         end else begin : g_gx
            AST_DIV_GX: assert property (
               @(posedge CLK_SYS) disable iff (RST)
               c.div[15:DIV_BITS_GX] == '0)
               else $error("generator holds divide bits above 4");
         end

         AST_NO_PIN_NO_REQ: assert property (
            @(posedge CLK_SYS) disable iff (RST)
            !c.pin_drive_enable && !PERIPH_REQ[n] |-> !run[n])
            else $error("generator runs without pin or request");

         AST_IDLE_LEVEL: assert property (
            @(posedge CLK_SYS) disable iff (RST)
            STANDBY && c.pin_drive_enable && !c.standby_keep_alive
            ##1 $stable(c) && STANDBY
            |-> GENERATOR_CLOCK_PIN_O[n] == c.idle_pin_level)
            else $error("pin not at idle level in standby");

         AST_KEEP_RUN: assert property (
            @(posedge CLK_SYS) disable iff (RST)
            STANDBY && c.generator_enable && c.pin_drive_enable
            && c.standby_keep_alive |-> run[n])
            else $error("keep-alive generator stopped in standby");

         AST_PIN_FOLLOWS: assert property (
            @(posedge CLK_SYS) disable iff (RST)
            run[n] && c.pin_drive_enable && (!STANDBY || c.standby_keep_alive)
            |=> GENERATOR_CLOCK_PIN_O[n] == $past(div_clk[n]))
            else $error("pin does not carry generator clock");

         AST_DISABLED: assert property (
            @(posedge CLK_SYS) disable iff (RST)
            !c.generator_enable [*2] |-> !GEN_CLK[n])
            else $error("clock out of a disabled generator");

         AST_RATIO_POW: assert property (
            @(posedge CLK_SYS) disable iff (RST)
            c.ratio_encoding_select && c.div == 16'h0003
            |-> ratio_of(c) == 32'h0000_0010)
            else $error("power-of-two ratio wrong");

         AST_RATIO_LIN: assert property (
            @(posedge CLK_SYS) disable iff (RST)
            !c.ratio_encoding_select && c.div <= 16'h0001
            |-> ratio_of(c) == ONE32)
            else $error("value 0 or 1 not divide by one");
      end else begin : g_pad
         assign ctrl_q[n] = '0;
      end
   end

   // ====================================================
   // bus checks
   AST_READ_BACK: assert property (
      @(posedge CLK_SYS) disable iff (RST)
      dph_d.rd && !fwd |=> HRDATA == $past(ctrl_q[a_idx]))
      else $error("read data does not match register");

   AST_UNMAPPED_ZERO: assert property (
      @(posedge CLK_SYS) disable iff (RST)
      a_valid && !a_hit && !HWRITE |=> HRDATA == RD_ZERO)
      else $error("unmapped read not zero");

endmodule
`default_nettype wire

// [design/gclk_pkg.sv]
// package: generator control register map, fields and types
`default_nettype none
package gclk_pkg;

   // ====================================================
   // map and sizes
   localparam int NUM_GEN_DEF = 12;
   localparam int NUM_SRC     = 32;
   localparam int ADDR_W      = 12;
   localparam int IDX_LSB     = 2;
   localparam int IDX_W       = 4;
   localparam int CNT_W       = 32;

   // ====================================================
   // fields
   localparam int DIV_LSB     = 16;
   localparam int DIV_BITS_G0 = 8;
   localparam int DIV_BITS_G1 = 16;
   localparam int DIV_BITS_GX = 5;
   localparam int EXP_MAX     = 30;
   localparam logic [2:0]  SIZE_WORD = 3'h2;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0100;
   localparam logic [31:0] LOW_WMASK = 32'h0000_3F1F;
   localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
   localparam logic [31:0] ONE32     = 32'h0000_0001;

   typedef struct packed {
      logic [15:0] div;
      logic [1:0]  rsv_hi;
      logic        standby_keep_alive;
      logic        ratio_encoding_select;
      logic        pin_drive_enable;
      logic        idle_pin_level;
      logic        duty_balance_enable;
      logic        generator_enable;
      logic [2:0]  rsv_lo;
      logic [4:0]  source_select;
   } gen_ctrl_type;

   typedef struct packed {
      logic             wr;
      logic             rd;
      logic [IDX_W-1:0] idx;
   } dphase_type;

   // writable bits of one generator's control word
   function automatic logic [31:0] write_mask(input int n);
      int bits;
      bits = (n == 0) ? DIV_BITS_G0 : (n == 1) ? DIV_BITS_G1 : DIV_BITS_GX;
      return LOW_WMASK | (((ONE32 << bits) - ONE32) << DIV_LSB);
   endfunction

   // effective divide ratio
   function automatic logic [CNT_W-1:0] ratio_of(input gen_ctrl_type c);
      logic [4:0] e;
      e = (c.div > EXP_MAX) ? 5'(EXP_MAX) : c.div[4:0];
      if (c.ratio_encoding_select)
         return ONE32 << (e + 5'h1);
      else if (c.div <= 16'h0001)
         return ONE32;
      else
         return CNT_W'(c.div);
   endfunction

endpackage
`default_nettype wire

// [design/gen_divider.sv]
// one generator's divider on a sampled source level
`timescale 1ns/1ns
`default_nettype none
module gen_divider
   import gclk_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             src_lvl,
   input  wire logic             run,
   input  wire logic [CNT_W-1:0] ratio,
   input  wire logic             duty_bal,
   output var  logic             clk_out
);

   logic             src_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] hi_len;
   logic             rise;
   logic             bypass;

   // ====================================================
   // count decode
   assign rise   = src_lvl & ~src_q;
   assign bypass = (ratio == ONE32);
   assign hi_len = duty_bal ? ((ratio >> 1) + (ratio & ONE32)) : (ratio >> 1);
   assign cnt_d  = (cnt_q >= ratio - ONE32) ? '0 : cnt_q + ONE32;

   // ====================================================
   // counter and output
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         src_q   <= 1'b0;
         cnt_q   <= '0;
         clk_out <= 1'b0;
      end else begin
         src_q <= src_lvl;
         if (!run) begin
            cnt_q   <= '0;
            clk_out <= 1'b0;
         end else if (bypass) begin
            cnt_q   <= '0;
            clk_out <= src_lvl;
         end else if (rise) begin
            cnt_q   <= cnt_d;
            clk_out <= (cnt_d < hi_len);
         end
      end
   end

   // ====================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_STOP_LOW: assert property (
      !run |=> !clk_out)
      else $error("divider output high while stopped");

   AST_BYPASS: assert property (
      run && bypass |=> clk_out == $past(src_lvl))
      else $error("divide by one does not follow source");

   AST_CNT_RANGE: assert property (
      run && !bypass && rise |=> cnt_q < $past(ratio))
      else $error("divider count beyond ratio");

   AST_HOLD_NO_EDGE: assert property (
      run && !bypass && !rise && $stable(ratio) && !$rose(run)
      |=> $stable(clk_out))
      else $error("divider output moved without source edge");

endmodule
`default_nettype wire

// [dv/clk_src_model.sv]
// clock source model: free-running source levels
`timescale 1ns/1ns
`default_nettype none
module clk_src_model (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   output var  logic [31:0] SRC_CLK
);
   logic [3:0] cnt_q;
   always_ff @(posedge CLK_SYS) begin
      if (RST) cnt_q <= 4'h0;
      else cnt_q <= cnt_q + 4'h1;
   end
   // even sources period 8, odd sources period 16
   always_comb begin
      for (int k = 0; k < 32; k++) SRC_CLK[k] = k[0] ? cnt_q[3] : cnt_q[2];
   end
endmodule
`default_nettype wire

// [dv/tb.sv]
// testbench for the generic clock generators
`timescale 1ns/1ns
`default_nettype none
module tb;
   import gclk_pkg::*;
   logic        clk, rst, hsel, hwrite, standby, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, src;
   logic [1:0]  htrans;
   logic [11:0] req, gclk, pin_o, pin_oe;
   int          error_cnt, n_checks;

   gclk_gen_ctrl i_gclk_gen_ctrl (.CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(SIZE_WORD), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .SRC_CLK(src), .PERIPH_REQ(req), .STANDBY(standby),
      .GEN_CLK(gclk), .GENERATOR_CLOCK_PIN_O(pin_o), .GENERATOR_CLOCK_PIN_OE(pin_oe));
   clk_src_model i_clk_src_model (.CLK_SYS(clk), .RST(rst), .SRC_CLK(src));

   // ====================================================
   // helpers
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   function automatic logic [31:0] mk(input logic [15:0] div, input logic sel, pin, idle, keep, en,
                                      input logic [4:0] s);
      return {div, 2'h0, keep, sel, pin, idle, 1'b0, en, 3'h0, s};
   endfunction

   // rising edges of a generator clock or pin over 512 cycles
   task automatic cnt_chk(input int g, input logic use_pin, input int e);
      int n;
      logic p, v;
      n = 0;
      p = 1'b0;
      repeat (512) begin
         @(posedge clk);
         v = use_pin ? pin_o[g] : gclk[g];
         if (v === 1'b1 && p === 1'b0) n++;
         p = v;
      end
      chk(((n >= e - 1) && (n <= e + 1)) ? e : n, e);
   endtask

   task automatic print_verdict;
      if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ====================================================
   // scenarios
   task automatic t_regs;
      logic [31:0] q;
      for (int g = 0; g < 12; g++) begin
         bus(1'b0, 32'(4 * g), 32'h0, q);
         chk(q, 32'h0000_0100);
      end
      bus(1'b1, 32'h0000_0000, 32'hFFFF_3F1F, q);
      bus(1'b0, 32'h0000_0000, 32'h0, q);
      chk(q, 32'h00FF_3F1F);
      bus(1'b1, 32'h0000_0004, 32'hFFFF_3F1F, q);
      bus(1'b0, 32'h0000_0004, 32'h0, q);
      chk(q, 32'hFFFF_3F1F);
      bus(1'b1, 32'h0000_002C, 32'hFFFF_3F1F, q);
      bus(1'b0, 32'h0000_002C, 32'h0, q);
      chk(q, 32'h001F_3F1F);
      bus(1'b1, 32'h0000_0030, 32'hFFFF_FFFF, q);
      bus(1'b0, 32'h0000_0030, 32'h0, q);
      chk(q, 32'h0000_0000);
      chk({31'h0, hresp}, 32'h0);
   endtask

   // high cycles of a divide-by-three clock with and without duty balance
   task automatic t_duty;
      logic [31:0] q;
      int          h;
      req <= 12'h001;
      for (int d = 0; d < 2; d++) begin
         bus(1'b1, 32'h0, mk(16'h3, 0, 0, 0, 0, 1, 5'h0) | (32'(d) << 9), q);
         repeat (24) @(posedge clk);
         h = 0;
         repeat (480) begin
            @(posedge clk);
            if (gclk[0] === 1'b1) h++;
         end
         chk(((h >= 160 * (d + 1) - 8) && (h <= 160 * (d + 1) + 8)) ? 32'h1 : 32'(h), 32'h1);
      end
      req <= 12'h000;
   endtask

   task automatic t_ratio;
      logic [31:0] q;
      logic [31:0] cfg [7];
      int          exp_n [7];
      cfg = '{mk(16'h4, 0, 0, 0, 0, 1, 5'h0), mk(16'h0, 0, 0, 0, 0, 1, 5'h0), mk(16'h1, 0, 0, 0, 0, 1, 5'h0),
              mk(16'h2, 0, 0, 0, 0, 1, 5'h0), mk(16'h1, 1, 0, 0, 0, 1, 5'h0), mk(16'h0, 1, 0, 0, 0, 1, 5'h0),
              mk(16'h1, 0, 0, 0, 0, 1, 5'h1)};
      exp_n = '{16, 64, 64, 32, 16, 32, 32};
      req <= 12'h001;
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, 32'h0, cfg[i], q);
         cnt_chk(0, 1'b0, exp_n[i]);
      end
      bus(1'b1, 32'h0, mk(16'h1, 0, 0, 0, 0, 0, 5'h0), q);
      cnt_chk(0, 1'b0, 0);
      req <= 12'h000;
   endtask

   task automatic t_standby;
      logic [31:0] q;
      standby <= 1'b1;
      bus(1'b1, 32'h8, mk(16'h1, 0, 0, 0, 1, 1, 5'h0), q);
      cnt_chk(2, 1'b0, 0);
      chk({31'h0, pin_oe[2]}, 32'h0);
      for (int l = 0; l < 2; l++) begin
         bus(1'b1, 32'h8, mk(16'h1, 0, 1, l[0], 0, 1, 5'h0), q);
         cnt_chk(2, 1'b1, 0);
         chk({31'h0, pin_o[2]}, 32'(l));
      end
      bus(1'b1, 32'h8, mk(16'h1, 0, 1, 0, 1, 1, 5'h0), q);
      cnt_chk(2, 1'b1, 64);
      chk({31'h0, pin_oe[2]}, 32'h1);
      req <= 12'h004;
      bus(1'b1, 32'h8, mk(16'h1, 0, 0, 0, 1, 1, 5'h0), q);
      cnt_chk(2, 1'b0, 64);
      standby <= 1'b0;
      req <= 12'h000;
   endtask

   // ====================================================
   // clock, reset, sequence, watchdog
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      error_cnt = 0;
      n_checks = 0;
      rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
      req = 12'h000; standby = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_ratio();
      t_duty();
      t_standby();
      print_verdict();
   end

   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
endmodule
`default_nettype wire
